// *** rtl/jbs_tap_port.sv ***
// Behaviour
// - Interrupted programming locks device, pins high-Z
// - Pin keeper holds pins during programming
// - Configuration starts out erased
// - TAP resets itself at power-up
// - SAMPLE/PRELOAD, EXTEST, BYPASS, IDCODE supported
// - Each input and I/O pin has cell
// - Chain covers I/O and dedicated input pins
// - I/O pin cell: three capture, two update stages; input pin cell: one capture stage
// - Separate pin and macrocell cell types
// - Capture stages chained from TDI to TDO
// - Capture samples, shifts, loads update stages
// - TAP controller generates all cell controls
// - Programming runs over the four test pins
// - Disabled port returns pins to user I/O
// - Optional pull-ups on mode and data-in
// - Secured device blocks readback, not ID/signature
`timescale 1ns/1ps
module jbs_tap_port
   import jbs_pkg::*;
#(
   parameter int          NUM_IO    = 96,
   parameter int          NUM_IN    = 4,
   parameter int          NUM_MC    = 16,
   parameter int          ISP_DEPTH = 16,
   // Arbitrary identification value
   parameter logic [31:0] ID_CODE   = 32'h00000001,
   parameter logic [31:0] USIG_INIT = 32'hFFFFFFFF
)(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  jbs_axi_req_t           axi_req_i,
   output jbs_axi_rsp_t           axi_rsp_o,
   input  wire logic              tck_i,
   input  wire logic              tms_i,
   input  wire logic              tdi_i,
   input  wire logic              user_tdo_i,
   input  wire logic              user_tdo_oe_i,
   output logic                   tdo_o,
   output logic                   tdo_oe_o,
   output logic [2:0]             jtag_user_o,
   output logic [1:0]             pullup_en_o,
   output logic                   lock_o,
   input  wire logic [NUM_IN-1:0] in_pad_i,
   input  wire logic [NUM_IO-1:0] io_pad_i,
   input  wire logic [NUM_IO-1:0] core_out_i,
   input  wire logic [NUM_IO-1:0] core_oe_i,
   input  wire logic [NUM_MC-1:0] mc_i,
   output logic [NUM_IO-1:0]      io_pad_o,
   output logic [NUM_IO-1:0]      io_pad_oe_o,
   output logic [NUM_MC-1:0]      mc_preload_o
);
   localparam int CHAIN  = 3 * NUM_IO + NUM_IN + NUM_MC;
   localparam int MC_LSB = 3 * NUM_IO + NUM_IN;
   localparam int AW     = $clog2(ISP_DEPTH);

   typedef struct packed {
      jbs_tap_t                    tap;
      logic [IR_W-1:0]             ir;
      logic [IR_W-1:0]             ir_sr;
      logic [CHAIN-1:0]            dr_sr;
      logic [CHAIN-1:0]            cap_s1;
      logic [CHAIN-1:0]            cap_s2;
      logic                        byp;
      logic [31:0]                 isp_sr;
      logic [NUM_IO-1:0]           upd_out;
      logic [NUM_IO-1:0]           upd_oe;
      logic [NUM_MC-1:0]           upd_mc;
      logic                        upd_tog;
      logic                        in_system_programming;
      logic                        locked;
      logic                        secured;
      logic                        erased;
      logic [AW-1:0]               addr;
      logic [ISP_DEPTH-1:0][31:0]  mem;
      logic [31:0]                 usig;
      logic [CTRL_W-1:0]           ctrl_s1;
      logic [CTRL_W-1:0]           ctrl_s2;
      logic                        ce_s1;
      logic                        ce_s2;
   } jbs_tck_st_t;

   typedef struct packed {
      logic              aw_got;
      logic [AXI_AW-1:0] awaddr;
      logic              w_got;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [CTRL_W-1:0] ctrl;
      logic [STAT_W-1:0] stat_s1;
      logic [STAT_W-1:0] stat_s2;
      logic              tog_s1;
      logic              tog_s2;
      logic              tog_s3;
      logic [NUM_IO-1:0] cp_out;
      logic [NUM_IO-1:0] cp_oe;
      logic [NUM_MC-1:0] cp_mc;
      logic [31:0]       cp_usig;
      logic [NUM_IO-1:0] pad;
      logic [NUM_IO-1:0] pad_oe;
      logic [NUM_IO-1:0] hold;
      logic [NUM_IO-1:0] hold_oe;
      logic [2:0]        pin_s1;
      logic [2:0]        pin_s2;
   } jbs_clk_st_t;

   jbs_tck_st_t       t_reg;
   jbs_tck_st_t       t_next;
   jbs_clk_st_t       c_reg;
   jbs_clk_st_t       c_next;
   logic [1:0]        trst_sync;
   logic              rst_t;
   logic [CHAIN-1:0]  cap_raw;
   logic [NUM_IO-1:0] ch_out;
   logic [NUM_IO-1:0] ch_oe;
   logic [NUM_MC-1:0] ch_mc;
   logic [1:0]        sel;
   logic              tdo_next;
   logic              tdo_reg;
   logic              tdo_en_reg;
   logic              aw_rdy;
   logic              w_rdy;
   logic              ar_rdy;

   function automatic jbs_tap_t tap_step(input jbs_tap_t s, input logic m);
      case (s)
         TAP_RESET:  return m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE:   return m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  return m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: return m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: return m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: return m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  return m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: return m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: return m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: return m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_IDLE;
         default:    return TAP_RESET;
      endcase
   endfunction

   // IN_SYSTEM_PROGRAMMING data registers are only reachable while programming is open
   function automatic logic [1:0] dr_sel(input logic [IR_W-1:0] ir, input logic in_system_programming);
      case (ir)
         IR_EXTEST, IR_SAMPLE:                      return DR_CHAIN;
         IR_IDCODE:                                 return DR_ISP;
         IR_ISP_ADR, IR_ISP_WR, IR_ISP_RD, IR_ISP_SIG: return in_system_programming ? DR_ISP : DR_BYP;
         default:                                   return DR_BYP;
      endcase
   endfunction

   always_ff @(posedge tck_i or posedge rst_i) begin
      if (rst_i) begin
         trst_sync <= 2'h3;
      end else begin
         trst_sync <= {trst_sync[0], 1'b0};
      end
   end
   assign rst_t = trst_sync[1];

   // Pin cells: pad, output, enable stages
   genvar g;
   generate
      for (g = 0; g < NUM_IO; g++) begin : g_io
         assign cap_raw[3*g]   = io_pad_i[g];
         assign cap_raw[3*g+1] = core_out_i[g];
         assign cap_raw[3*g+2] = core_oe_i[g];
         assign ch_out[g]      = t_reg.dr_sr[3*g+1];
         assign ch_oe[g]       = t_reg.dr_sr[3*g+2];
      end
      for (g = 0; g < NUM_IN; g++) begin : g_in
         assign cap_raw[3*NUM_IO+g] = in_pad_i[g];
      end
      for (g = 0; g < NUM_MC; g++) begin : g_mc
         assign cap_raw[MC_LSB+g] = mc_i[g];
         assign ch_mc[g]          = t_reg.dr_sr[MC_LSB+g];
      end
   endgenerate

   assign sel = dr_sel(t_reg.ir, t_reg.in_system_programming);

   always_comb begin
      t_next        = t_reg;
      t_next.ce_s1  = ce_i;
      t_next.ce_s2  = t_reg.ce_s1;
      t_next.ctrl_s1 = c_reg.ctrl;
      t_next.ctrl_s2 = t_reg.ctrl_s1;
      t_next.cap_s1 = cap_raw;
      t_next.cap_s2 = t_reg.cap_s1;
      if (t_reg.ce_s2) begin
         t_next.tap = tap_step(t_reg.tap, tms_i);
         if (!t_reg.ctrl_s2[CTRL_PORT]) begin
            t_next.tap = TAP_RESET;
         end
         case (t_reg.tap)
            TAP_RESET: begin
               t_next.ir = IR_IDCODE;
               if (t_reg.in_system_programming) begin
                  t_next.locked = 1'b1;
                  t_next.in_system_programming    = 1'b0;
               end
            end
            TAP_CAP_IR: t_next.ir_sr = IR_CAPTURE;
            TAP_SH_IR:  t_next.ir_sr = {tdi_i, t_reg.ir_sr[IR_W-1:1]};
            TAP_UPD_IR: begin
               t_next.ir = t_reg.ir_sr;
               case (t_reg.ir_sr)
                  IR_ISP_ENT: t_next.in_system_programming = 1'b1;
                  IR_ISP_EXT: begin
                     if (t_reg.in_system_programming) begin
                        t_next.in_system_programming    = 1'b0;
                        t_next.locked = 1'b0;
                     end
                  end
                  IR_ISP_ERA: begin
                     if (t_reg.in_system_programming) begin
                        t_next.mem     = '1;
                        t_next.secured = 1'b0;
                        t_next.erased  = 1'b1;
                     end
                  end
                  IR_ISP_FUS: t_next.secured = t_reg.in_system_programming | t_reg.secured;
                  default: ;
               endcase
            end
            TAP_CAP_DR: begin
               t_next.byp = 1'b0;
               if (sel == DR_CHAIN) begin
                  t_next.dr_sr = t_reg.cap_s2;
               end
               case (t_reg.ir)
                  IR_IDCODE:  t_next.isp_sr = ID_CODE;
                  IR_ISP_RD:  t_next.isp_sr = t_reg.secured ? '0 : t_reg.mem[t_reg.addr];
                  IR_ISP_SIG: t_next.isp_sr = t_reg.usig;
                  default:    t_next.isp_sr = '0;
               endcase
            end
            TAP_SH_DR: begin
               case (sel)
                  DR_CHAIN: t_next.dr_sr  = {tdi_i, t_reg.dr_sr[CHAIN-1:1]};
                  DR_ISP:   t_next.isp_sr = {tdi_i, t_reg.isp_sr[31:1]};
                  default:  t_next.byp    = tdi_i;
               endcase
            end
            TAP_UPD_DR: begin
               if (sel == DR_CHAIN) begin
                  t_next.upd_out = ch_out;
                  t_next.upd_oe  = ch_oe;
                  t_next.upd_mc  = ch_mc;
                  t_next.upd_tog = ~t_reg.upd_tog;
               end else if (sel == DR_ISP) begin
                  case (t_reg.ir)
                     IR_ISP_ADR: t_next.addr = t_reg.isp_sr[AW-1:0];
                     IR_ISP_WR: begin
                        t_next.mem[t_reg.addr] = t_reg.isp_sr;
                        t_next.erased          = 1'b0;
                     end
                     IR_ISP_SIG: begin
                        t_next.usig    = t_reg.isp_sr;
                        t_next.upd_tog = ~t_reg.upd_tog;
                     end
                     default: ;
                  endcase
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge tck_i or posedge rst_t) begin
      if (rst_t) begin
         t_reg         <= '0;
         t_reg.tap     <= TAP_RESET;
         t_reg.ir      <= IR_IDCODE;
         t_reg.ctrl_s1 <= CTRL_RST;
         t_reg.ctrl_s2 <= CTRL_RST;
         t_reg.mem     <= '1;
         t_reg.erased  <= 1'b1;
         t_reg.usig    <= USIG_INIT;
      end else begin
         t_reg <= t_next;
      end
   end

   always_comb begin
      case (t_reg.tap)
         TAP_SH_IR: tdo_next = t_reg.ir_sr[0];
         TAP_SH_DR: tdo_next = (sel == DR_CHAIN) ? t_reg.dr_sr[0] :
                               (sel == DR_ISP) ? t_reg.isp_sr[0] : t_reg.byp;
         default:   tdo_next = 1'b0;
      endcase
   end

   always_ff @(negedge tck_i or posedge rst_t) begin
      if (rst_t) begin
         tdo_reg    <= 1'b0;
         tdo_en_reg <= 1'b0;
      end else begin
         tdo_reg    <= tdo_next;
         tdo_en_reg <= t_reg.ce_s2 && (t_reg.tap == TAP_SH_IR || t_reg.tap == TAP_SH_DR);
      end
   end

   assign aw_rdy = ce_i && !c_reg.aw_got && !c_reg.bvalid;
   assign w_rdy  = ce_i && !c_reg.w_got && !c_reg.bvalid;
   assign ar_rdy = ce_i && !c_reg.rvalid;

   always_comb begin
      c_next         = c_reg;
      c_next.stat_s1 = {t_reg.ir == IR_EXTEST, t_reg.erased, t_reg.secured, t_reg.in_system_programming, t_reg.locked};
      c_next.stat_s2 = c_reg.stat_s1;
      c_next.tog_s1  = t_reg.upd_tog;
      c_next.tog_s2  = c_reg.tog_s1;
      c_next.tog_s3  = c_reg.tog_s2;
      c_next.pin_s1  = {tck_i, tms_i, tdi_i};
      c_next.pin_s2  = c_reg.pin_s1;
      if (ce_i) begin
         // Update words are stable for many TCK periods after the toggle
         if (c_reg.tog_s3 != c_reg.tog_s2) begin
            c_next.cp_out  = t_reg.upd_out;
            c_next.cp_oe   = t_reg.upd_oe;
            c_next.cp_mc   = t_reg.upd_mc;
            c_next.cp_usig = t_reg.usig;
         end
         if (c_reg.bvalid && axi_req_i.bready) begin
            c_next.bvalid = 1'b0;
         end
         if (c_reg.rvalid && axi_req_i.rready) begin
            c_next.rvalid = 1'b0;
         end
         if (axi_req_i.awvalid && aw_rdy) begin
            c_next.aw_got = 1'b1;
            c_next.awaddr = axi_req_i.awaddr;
         end
         if (axi_req_i.wvalid && w_rdy) begin
            c_next.w_got = 1'b1;
            c_next.wdata = axi_req_i.wdata;
            c_next.wstrb = axi_req_i.wstrb;
         end
         if (c_reg.aw_got && c_reg.w_got) begin
            c_next.aw_got = 1'b0;
            c_next.w_got  = 1'b0;
            c_next.bvalid = 1'b1;
            c_next.bresp  = RESP_OKAY;
            case (c_reg.awaddr)
               OFF_CTRL: begin
                  if (c_reg.wstrb[0]) begin
                     c_next.ctrl = c_reg.wdata[CTRL_W-1:0];
                  end
               end
               OFF_STATUS, OFF_IDCODE, OFF_USIG: ;
               default: c_next.bresp = RESP_SLV;
            endcase
         end
         if (axi_req_i.arvalid && ar_rdy) begin
            c_next.rvalid = 1'b1;
            c_next.rresp  = RESP_OKAY;
            case (axi_req_i.araddr)
               OFF_CTRL:   c_next.rdata = {{(32-CTRL_W){1'b0}}, c_reg.ctrl};
               OFF_STATUS: c_next.rdata = {{(32-STAT_W){1'b0}}, c_reg.stat_s2};
               OFF_IDCODE: c_next.rdata = ID_CODE;
               OFF_USIG:   c_next.rdata = c_reg.cp_usig;
               default: begin
                  c_next.rdata = '0;
                  c_next.rresp = RESP_SLV;
               end
            endcase
         end
         if (c_reg.stat_s2[ST_LOCKED]) begin
            c_next.pad_oe = '0;
         end else if (c_reg.stat_s2[ST_ISP]) begin
            c_next.pad    = c_reg.ctrl[CTRL_KEEP] ? c_reg.hold : c_reg.pad;
            c_next.pad_oe = c_reg.ctrl[CTRL_KEEP] ? c_reg.hold_oe : '0;
         end else if (c_reg.stat_s2[ST_EXTEST]) begin
            c_next.pad    = c_reg.cp_out;
            c_next.pad_oe = c_reg.cp_oe;
         end else begin
            c_next.pad    = core_out_i;
            c_next.pad_oe = core_oe_i;
         end
         if (!c_reg.stat_s2[ST_ISP]) begin
            c_next.hold    = c_reg.pad;
            c_next.hold_oe = c_reg.pad_oe;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         c_reg         <= '0;
         c_reg.ctrl    <= CTRL_RST;
         c_reg.cp_usig <= USIG_INIT;
      end else begin
         c_reg <= c_next;
      end
   end

   assign axi_rsp_o = '{awready: aw_rdy, wready: w_rdy, bresp: c_reg.bresp, bvalid: c_reg.bvalid,
                        arready: ar_rdy, rdata: c_reg.rdata, rresp: c_reg.rresp, rvalid: c_reg.rvalid};
   // Test pins revert to user I/O
   assign tdo_o        = c_reg.ctrl[CTRL_PORT] ? tdo_reg : user_tdo_i;
   assign tdo_oe_o     = c_reg.ctrl[CTRL_PORT] ? tdo_en_reg : user_tdo_oe_i;
   assign jtag_user_o  = c_reg.ctrl[CTRL_PORT] ? 3'h0 : c_reg.pin_s2;
   assign pullup_en_o  = {c_reg.ctrl[CTRL_PU_MS], c_reg.ctrl[CTRL_PU_DI]};
   assign lock_o       = c_reg.stat_s2[ST_LOCKED];
   assign io_pad_o     = c_reg.pad;
   assign io_pad_oe_o  = c_reg.pad_oe;
   assign mc_preload_o = c_reg.cp_mc;

   sequence s_tms_five;
      (tms_i && t_reg.ce_s2) [*5];
   endsequence
   sequence s_keep_two;
      (ce_i && c_reg.stat_s2[ST_ISP] && !c_reg.stat_s2[ST_LOCKED] && c_reg.ctrl[CTRL_KEEP]) [*2];
   endsequence

   a_tap_reset_seq: assert property (@(posedge tck_i) disable iff (rst_t)
      s_tms_five |=> t_reg.tap == TAP_RESET) else $error("five TMS ones did not reset TAP");
   a_ir_capture: assert property (@(posedge tck_i) disable iff (rst_t)
      t_reg.ce_s2 && t_reg.tap == TAP_CAP_IR |=> t_reg.ir_sr == IR_CAPTURE) else $error("bad IR capture");
   a_bypass_zero: assert property (@(posedge tck_i) disable iff (rst_t)
      t_reg.ce_s2 && t_reg.tap == TAP_CAP_DR && sel == DR_BYP |=> !t_reg.byp) else $error("bypass not zero");
   a_lock_on_reset: assert property (@(posedge tck_i) disable iff (rst_t)
      t_reg.ce_s2 && t_reg.tap == TAP_RESET && t_reg.in_system_programming |=> t_reg.locked && !t_reg.in_system_programming)
      else $error("no lock after interrupt");
   a_secure_read: assert property (@(posedge tck_i) disable iff (rst_t)
      t_reg.ce_s2 && t_reg.tap == TAP_CAP_DR && t_reg.ir == IR_ISP_RD && t_reg.in_system_programming && t_reg.secured
      |=> t_reg.isp_sr == '0) else $error("secured readback leaked");
   a_erase_state: assert property (@(posedge tck_i) disable iff (rst_t)
      t_reg.ce_s2 && t_reg.tap == TAP_UPD_IR && t_reg.ir_sr == IR_ISP_ERA && t_reg.in_system_programming
      |=> t_reg.erased && !t_reg.secured) else $error("erase failed");
   a_chain_shift: assert property (@(posedge tck_i) disable iff (rst_t)
      t_reg.ce_s2 && t_reg.tap == TAP_SH_DR && sel == DR_CHAIN
      |=> t_reg.dr_sr[CHAIN-1] == $past(tdi_i)) else $error("chain shift wrong");
   a_lock_hiz: assert property (@(posedge clock_i) disable iff (rst_i)
      ce_i && c_reg.stat_s2[ST_LOCKED] |=> io_pad_oe_o == '0) else $error("locked pin driven");
   a_keep_pins: assert property (@(posedge clock_i) disable iff (rst_i)
      s_keep_two |=> $stable(io_pad_o) && $stable(io_pad_oe_o)) else $error("keeper lost state");
   a_bus_bhold: assert property (@(posedge clock_i) disable iff (rst_i)
      c_reg.bvalid && !axi_req_i.bready |=> c_reg.bvalid) else $error("bvalid dropped");
endmodule

// *** rtl/jbs_pkg.sv ***
package jbs_pkg;
   localparam int          IR_W       = 4;
   localparam int          AXI_AW     = 8;
   localparam int          CTRL_W     = 4;
   localparam int          STAT_W     = 5;
   localparam logic [3:0]  IR_EXTEST  = 4'h0;
   localparam logic [3:0]  IR_SAMPLE  = 4'h1;
   localparam logic [3:0]  IR_IDCODE  = 4'h2;
   localparam logic [3:0]  IR_ISP_EXT = 4'h7;
   localparam logic [3:0]  IR_ISP_ENT = 4'h8;
   localparam logic [3:0]  IR_ISP_ADR = 4'h9;
   localparam logic [3:0]  IR_ISP_WR  = 4'hA;
   localparam logic [3:0]  IR_ISP_RD  = 4'hB;
   localparam logic [3:0]  IR_ISP_ERA = 4'hC;
   localparam logic [3:0]  IR_ISP_FUS = 4'hD;
   localparam logic [3:0]  IR_ISP_SIG = 4'hE;
   localparam logic [3:0]  IR_BYPASS  = 4'hF;
   localparam logic [3:0]  IR_CAPTURE = 4'h1;
   localparam logic [1:0]  DR_BYP     = 2'h0;
   localparam logic [1:0]  DR_CHAIN   = 2'h1;
   localparam logic [1:0]  DR_ISP     = 2'h2;
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_STATUS = 8'h04;
   localparam logic [7:0]  OFF_IDCODE = 8'h08;
   localparam logic [7:0]  OFF_USIG   = 8'h0C;
   localparam int          CTRL_PORT  = 0;
   localparam int          CTRL_PU_MS = 1;
   localparam int          CTRL_PU_DI = 2;
   localparam int          CTRL_KEEP  = 3;
   localparam logic [3:0]  CTRL_RST   = 4'h1;
   localparam int          ST_LOCKED  = 0;
   localparam int          ST_ISP     = 1;
   localparam int          ST_SECURE  = 2;
   localparam int          ST_ERASED  = 3;
   localparam int          ST_EXTEST  = 4;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
      TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } jbs_tap_t;

   typedef struct packed {
      logic [AXI_AW-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [AXI_AW-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } jbs_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } jbs_axi_rsp_t;
endpackage

// *** tb/jbs_jtag_host.sv ***
`timescale 1ns/1ps
module jbs_jtag_host(
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   task automatic tk(input logic m, input logic d, output logic o);
      tms_o = m;
      tdi_o = d;
      #15 tck_o = 1'b1;
      o = tdo_i;
      #15 tck_o = 1'b0;
   endtask
   task automatic home();
      logic o;
      repeat (8) tk(1'b1, 1'b1, o);
      tk(1'b0, 1'b1, o);
   endtask
   task automatic scan(input bit ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic o;
      dout = '0;
      // Outside the shift TDI rests at its pull-up level
      tk(1'b1, 1'b1, o);
      if (ir) tk(1'b1, 1'b1, o);
      tk(1'b0, 1'b1, o);
      tk(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) tk(i == n - 1, din[i], dout[i]);
      tk(1'b1, 1'b1, o);
      tk(1'b0, 1'b1, o);
   endtask
endmodule

// *** tb/jbs_tap_port_bench.sv ***
`timescale 1ns/1ps
module jbs_tap_port_bench;
   import jbs_pkg::*;
   localparam logic [31:0] IDV    = 32'h00000001;
   localparam logic [33:0] EX [5] = '{34'h1, 34'h8, {2'h0, IDV}, 34'h0FFFFFFFF, 34'h200000000};
   logic clock_i, rst_i, ce_i, tck_i, tms_i, tdi_i, user_tdo_i, user_tdo_oe_i, tdo_o, tdo_oe_o, lock_o;
   logic [2:0]  jtag_user_o;
   logic [1:0]  pullup_en_o, rs;
   logic [3:0]  in_pad_i, io_pad_i, core_out_i, core_oe_i, mc_i, io_pad_o, io_pad_oe_o, mc_preload_o;
   logic [15:0] r;
   logic [31:0] rv;
   logic [63:0] d, e;
   logic [3:0]  xo, xe, xm;
   logic [19:0] p;
   jbs_axi_req_t req;
   jbs_axi_rsp_t rsp;
   int failures = 0, total_checks = 0, cyc = 0, ctrl_m = 1;
   jbs_tap_port #(.NUM_IO(4), .NUM_IN(4), .NUM_MC(4), .ID_CODE(IDV)) uut(.clock_i, .rst_i, .ce_i,
      .axi_req_i(req), .axi_rsp_o(rsp), .tck_i, .tms_i, .tdi_i, .user_tdo_i, .user_tdo_oe_i, .tdo_o, .tdo_oe_o,
      .jtag_user_o, .pullup_en_o, .lock_o, .in_pad_i, .io_pad_i, .core_out_i, .core_oe_i, .mc_i, .io_pad_o,
      .io_pad_oe_o, .mc_preload_o);
   jbs_jtag_host host(.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      total_checks++;
      if (g !== x) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
      @(posedge clock_i);
      req.awaddr <= a;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      {req.awvalid, req.wvalid, req.bready} <= 3'h7;
      do begin
         @(posedge clock_i);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      q = rsp.bresp;
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
      @(posedge clock_i);
      req.araddr <= a;
      {req.arvalid, req.rready} <= 2'h3;
      do begin
         @(posedge clock_i);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      {q, v} = {rsp.rresp, rsp.rdata};
      req.rready <= 1'b0;
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      {rst_i, ce_i, user_tdo_i, user_tdo_oe_i} = 4'hC;
      {in_pad_i, io_pad_i, core_out_i, core_oe_i, mc_i} = '0;
      req = '0;
      r = 16'h0005;
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(8'(i * 4), rv, rs);
         chk({rs, rv}, EX[i]);
      end
      ce_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk({rsp.awready, rsp.wready, rsp.arready}, 3'h0);
      ce_i <= 1'b1;
      $display("end of register test");
      ctrl_m = 3;
      wr(OFF_CTRL, 32'(ctrl_m), rs);
      wr(8'h20, 32'h0, rs);
      chk(rs, RESP_SLV);
      repeat (3) @(posedge clock_i);
      chk({pullup_en_o, jtag_user_o}, {ctrl_m[1], ctrl_m[2], 3'h0});
      host.home();
      host.scan(0, 32, 64'h0, d);
      chk(d[31:0], IDV);
      host.scan(1, 4, {60'h0, IR_BYPASS}, d);
      chk(d[3:0], IR_CAPTURE);
      host.scan(0, 2, 64'h1, d);
      chk(d[1:0], 2'h2);
      $display("end of scan test");
      @(posedge clock_i);
      r = lfsr(r);
      {in_pad_i, io_pad_i, core_out_i, core_oe_i} <= r;
      mc_i <= ~r[3:0];
      repeat (4) @(posedge clock_i);
      e = '0;
      for (int i = 0; i < 4; i++) begin
         {e[3 * i + 2], e[3 * i + 1], e[3 * i]} = {core_oe_i[i], core_out_i[i], io_pad_i[i]};
         {e[16 + i], e[12 + i]} = {mc_i[i], in_pad_i[i]};
      end
      host.scan(1, 4, {60'h0, IR_SAMPLE}, d);
      host.scan(0, 20, 64'h0, d);
      chk(d, e);
      r = lfsr(r);
      p = {r[3:0], ~r};
      host.scan(1, 4, {60'h0, IR_EXTEST}, d);
      host.scan(0, 20, {44'h0, p}, d);
      chk(d, e);
      for (int i = 0; i < 4; i++) begin
         {xe[i], xo[i], xm[i]} = {p[3 * i + 2], p[3 * i + 1], p[16 + i]};
      end
      repeat (8) @(posedge clock_i);
      chk({io_pad_oe_o, io_pad_o, mc_preload_o}, {xe, xo, xm});
      ctrl_m = 0;
      wr(OFF_CTRL, 32'(ctrl_m), rs);
      {user_tdo_i, user_tdo_oe_i} <= 2'h3;
      repeat (4) @(posedge clock_i);
      chk({tdo_oe_o, tdo_o}, 2'h3);
      chk(jtag_user_o, {tck_i, tms_i, tdi_i});
      ctrl_m = 9;
      wr(OFF_CTRL, 32'(ctrl_m), rs);
      host.home();
      host.scan(1, 4, {60'h0, IR_ISP_ENT}, d);
      repeat (4) @(posedge clock_i);
      {xo, xe} = {core_out_i, core_oe_i};
      {core_out_i, core_oe_i} <= ~{core_out_i, core_oe_i};
      repeat (4) @(posedge clock_i);
      chk({io_pad_o, io_pad_oe_o}, {xo, xe});
      host.scan(1, 4, {60'h0, IR_ISP_RD}, d);
      host.scan(0, 32, 64'h0, d);
      chk(d[31:0], 32'hFFFFFFFF);
      host.scan(1, 4, {60'h0, IR_ISP_FUS}, d);
      host.scan(1, 4, {60'h0, IR_ISP_RD}, d);
      host.scan(0, 32, 64'h0, d);
      chk(d[31:0], 32'h0);
      host.scan(1, 4, {60'h0, IR_IDCODE}, d);
      host.scan(0, 32, 64'h0, d);
      chk(d[31:0], IDV);
      host.home();
      for (int i = 0; i < 50 && lock_o !== 1'b1; i++) @(posedge clock_i);
      repeat (2) @(posedge clock_i);
      chk({lock_o, io_pad_oe_o}, 5'h10);
      rd(OFF_STATUS, rv, rs);
      chk(rv[4:0], 5'h0D);
      $display("end of lock test");
      stop_test();
   end
endmodule
